/* File: adwwd_defs.vh */
// Constants for the analog-die window watchdog
// Functional notes
// - Counts only in Normal mode, base clock
// - Timeout select: 10 ms doubling to 1280 ms
// - Low power inactive; Stop read shows disabled
// - Initial fixed timeout; window flag set; config ignored
// - Initial phase: timeout or non-0xAA resets
// - Window: service only in second half
// - Config bit 6 shows window open
// - Window: timeout or wrong value resets
// - Config bit 7 set while debug disabled
// - Disable clears service; restart initial sequence
// - Low power stops clock, clears service
// - Service writes while disabled are ignored
// - Correct open-window write restarts, flips expected
// - Debug pin condition holds watchdog fully off
`ifndef ADWWD_DEFS_VH
`define ADWWD_DEFS_VH

// ----------------------------------------------------------------
// Register layout
// ----------------------------------------------------------------
`define ADWWD_CFG_OFF_BIT    7
`define ADWWD_CFG_WIN_BIT    6
`define ADWWD_CFG_TO_MSB     2
`define ADWWD_CFG_TO_LSB     0
`define ADWWD_CFG_RESET      8'h00
`define ADWWD_TSEL_RESET     3'h0
`define ADWWD_SVC_RESET      8'h00
`define ADWWD_SVC_FIRST      8'hAA
`define ADWWD_SVC_SECOND     8'h55
`define ADWWD_SEL_CONFIG     1'b0
`define ADWWD_SEL_SERVICE    1'b1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADWWD_CLK_PERIOD_PS  5000
`define ADWWD_HALF_BASE_MS   5
`define ADWWD_TICK_CYCLES    ((`ADWWD_HALF_BASE_MS * 1000000) / (`ADWWD_CLK_PERIOD_PS / 1000))
`define ADWWD_INIT_TICKS     32

`endif

/* File: adwwd_host.sv */
// Host model: toggle-handshake register writer
`timescale 1ns/1ps
`default_nettype none
module adwwd_host (
  input  wire logic       clk,
  input  wire logic       ack,
  output var  logic       tgl = 1'b0,
  output var  logic       sel = 1'b0,
  output var  logic [7:0] data = 8'h00
);
  int n_tmo = 0;
  // Held until acknowledged or 20 edges pass; stale data inverted so it is never reused
  task automatic wr(input logic s, input logic [7:0] d);
    int n;
    n = 0;
    sel <= s;
    data <= d;
    tgl <= ~tgl;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== tgl && n < 20);
    if (ack !== tgl) n_tmo++;
    data <= ~d;
    // One edge passes so a following write never reassigns data in this step
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: adwwd_sva.sv */
// Concurrent checks on the window watchdog ports
`timescale 1ns/1ps
`default_nettype none
module adwwd_sva (
  input wire logic       CLOCK,
  input wire logic       RST_N,
  input wire logic       WR_TOGGLE,
  input wire logic       WR_SEL,
  input wire logic [7:0] WR_DATA,
  input wire logic       WR_ACK,
  input wire logic [7:0] CONFIG_RDATA,
  input wire logic [7:0] SERVICE_RDATA,
  input wire logic       LOW_POWER,
  input wire logic       TEST_LEVEL_ON_TEST_CLOCK_PIN,
  input wire logic       TEST_MODE_PIN,
  input wire logic       WDOG_RESET
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire dbg = TEST_LEVEL_ON_TEST_CLOCK_PIN && !TEST_MODE_PIN;
  a_pulse_one: assert property (WDOG_RESET |=> !WDOG_RESET) else $error("pulse");
  a_restart_init: assert property (WDOG_RESET |-> ##3 CONFIG_RDATA[6]) else $error("restart");
  a_ack_sync: assert property ($changed(WR_TOGGLE) |=> $stable(WR_ACK)) else $error("sync");
  a_ack_bound: assert property (WR_ACK != WR_TOGGLE |-> ##[1:4] WR_ACK == WR_TOGGLE) else $error("ack");
  a_lp_off: assert property (LOW_POWER [*6] |-> CONFIG_RDATA[7]) else $error("lp flag");
  a_lp_clear: assert property (LOW_POWER [*6] |-> SERVICE_RDATA == 8'h00) else $error("lp svc");
  a_dbg_off: assert property (dbg [*6] |-> CONFIG_RDATA[7]) else $error("dbg flag");
  a_off_quiet: assert property (CONFIG_RDATA[7] |-> !WDOG_RESET) else $error("off reset");
  a_svc_store: assert property ($changed(SERVICE_RDATA) && SERVICE_RDATA != 8'h00 |->
    $changed(WR_ACK) && WR_SEL && SERVICE_RDATA == WR_DATA) else $error("store");
  cover property (WDOG_RESET);
  cover property (SERVICE_RDATA == 8'h55);
  cover property (CONFIG_RDATA[7]);
endmodule
bind adwwd_top adwwd_sva u_sva (.*);
`default_nettype wire

/* File: adwwd_top.v */
// Window watchdog core of the analog die, with host register access
`timescale 1ns/1ps
`default_nettype none
`include "adwwd_defs.vh"

module adwwd_top #(
  parameter integer TICK_CYCLES = `ADWWD_TICK_CYCLES,
  parameter integer INIT_TICKS  = `ADWWD_INIT_TICKS
) (
  input  wire       CLOCK,
  input  wire       RST_N,
  input  wire       WR_TOGGLE,
  input  wire       WR_SEL,
  input  wire [7:0] WR_DATA,
  output wire       WR_ACK,
  output wire [7:0] CONFIG_RDATA,
  output wire [7:0] SERVICE_RDATA,
  input  wire       LOW_POWER,
  input  wire       TEST_LEVEL_ON_TEST_CLOCK_PIN,
  input  wire       TEST_MODE_PIN,
  output reg        WDOG_RESET
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_OFF  = 3'h1;
  localparam [2:0] ST_INIT = 3'h2;
  localparam [2:0] ST_WIN  = 3'h4;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [1:0] wr_sync;
  reg       wr_seen;
  reg [1:0] lp_sync;
  reg [1:0] tlvl_sync;
  reg [1:0] tmode_sync;

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      wr_sync    <= 2'h0;
      wr_seen    <= 1'b0;
      lp_sync    <= 2'h0;
      tlvl_sync  <= 2'h0;
      tmode_sync <= 2'h3;
    end else begin
      wr_sync    <= {wr_sync[0], WR_TOGGLE};
      wr_seen    <= wr_sync[1];
      lp_sync    <= {lp_sync[0], LOW_POWER};
      tlvl_sync  <= {tlvl_sync[0], TEST_LEVEL_ON_TEST_CLOCK_PIN};
      tmode_sync <= {tmode_sync[0], TEST_MODE_PIN};
    end
  end

  // Data and select are held by the host until the acknowledge toggles
  wire wr_event   = wr_sync[1] ^ wr_seen;
  wire svc_wr     = wr_event && (WR_SEL == `ADWWD_SEL_SERVICE);
  wire cfg_wr     = wr_event && (WR_SEL == `ADWWD_SEL_CONFIG);
  wire debug_off  = tlvl_sync[1] && !tmode_sync[1];
  wire low_power  = lp_sync[1];
  wire disabled   = debug_off || low_power;

  assign WR_ACK = wr_seen;

  // ----------------------------------------------------------------
  // Base tick prescaler: one tick per half of the shortest window
  // ----------------------------------------------------------------
  // Prescaler restarts with the tick counter, so the closed half of a
  // window is never cut short by a partly elapsed tick
  reg        next_restart;
  reg [31:0] pre_cnt;
  wire       tick = (pre_cnt == TICK_CYCLES - 1);

  always @(posedge CLOCK) begin
    if (!RST_N || disabled) begin
      pre_cnt <= 32'h0;
    end else if (tick || next_restart) begin
      pre_cnt <= 32'h0;
    end else begin
      pre_cnt <= pre_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog sequencer
  // ----------------------------------------------------------------
  reg  [2:0]  state;
  reg  [9:0]  tick_cnt;
  reg  [2:0]  timeout_select;
  reg  [7:0]  service_value;
  reg  [7:0]  expect_value;

  // Half window in ticks is 2^select, so a full window spans 10 ms << select
  wire [9:0] half_ticks = 10'h1 << timeout_select;
  wire [9:0] full_ticks = half_ticks << 1;
  wire       window_open_flag = (state == ST_INIT) ||
                                ((state == ST_WIN) && (tick_cnt >= half_ticks));
  wire       init_expired = (state == ST_INIT) && tick && (tick_cnt == INIT_TICKS - 1);
  wire       win_expired  = (state == ST_WIN) && tick && (tick_cnt == full_ticks - 10'h1);

  reg  [2:0] next_state;
  reg  [9:0] next_tick_cnt;
  reg  [7:0] next_expect;
  reg        next_fault;

  always @* begin
    next_state    = state;
    next_tick_cnt = tick ? tick_cnt + 10'h1 : tick_cnt;
    next_expect   = expect_value;
    next_fault    = 1'b0;
    next_restart  = 1'b0;
    case (state)
      ST_OFF: begin
        next_tick_cnt = 10'h0;
        next_expect   = `ADWWD_SVC_FIRST;
        if (!disabled) begin
          next_state = ST_INIT;
          next_restart = 1'b1;
        end
      end
      ST_INIT: begin
        if (svc_wr) begin
          if (WR_DATA == `ADWWD_SVC_FIRST) begin
            next_state    = ST_WIN;
            next_tick_cnt = 10'h0;
            next_restart  = 1'b1;
            next_expect   = `ADWWD_SVC_SECOND;
          end else begin
            next_fault = 1'b1;
          end
        end else if (init_expired) begin
          next_fault = 1'b1;
        end
      end
      ST_WIN: begin
        if (svc_wr) begin
          if (window_open_flag && (WR_DATA == expect_value)) begin
            next_tick_cnt = 10'h0;
            next_restart  = 1'b1;
            next_expect   = ~expect_value;
          end else begin
            next_fault = 1'b1;
          end
        end else if (win_expired) begin
          next_fault = 1'b1;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    // A fault restarts the initial phase at once, no external reset awaited
    if (next_fault) begin
      next_state    = ST_INIT;
      next_tick_cnt = 10'h0;
      next_expect   = `ADWWD_SVC_FIRST;
      next_restart  = 1'b1;
    end
    // Disable overrides a fault raised in the same cycle
    if (disabled) begin
      next_state    = ST_OFF;
      next_tick_cnt = 10'h0;
      next_expect   = `ADWWD_SVC_FIRST;
      next_fault    = 1'b0;
    end
  end

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      state        <= ST_INIT;
      tick_cnt     <= 10'h0;
      expect_value <= `ADWWD_SVC_FIRST;
      WDOG_RESET   <= 1'b0;
    end else begin
      state        <= next_state;
      tick_cnt     <= next_tick_cnt;
      expect_value <= next_expect;
      WDOG_RESET   <= next_fault;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Config may be written in any phase; the initial phase ignores it
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      timeout_select <= `ADWWD_TSEL_RESET;
    end else if (cfg_wr) begin
      timeout_select <= WR_DATA[`ADWWD_CFG_TO_MSB:`ADWWD_CFG_TO_LSB];
    end
  end

  always @(posedge CLOCK) begin
    if (!RST_N || disabled) begin
      service_value <= `ADWWD_SVC_RESET;
    // The off-to-initial step ignores a service write, so it is not stored
    end else if (svc_wr && !next_fault && (state != ST_OFF)) begin
      service_value <= WR_DATA;
    end else if (next_fault) begin
      service_value <= `ADWWD_SVC_RESET;
    end
  end

  // Status bits are registered; the window bit trails the state by one cycle, the off bit changes with it
  reg off_flag;
  reg win_flag;
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      off_flag <= 1'b0;
      win_flag <= 1'b0;
    end else begin
      off_flag <= disabled;
      win_flag <= window_open_flag;
    end
  end

  assign CONFIG_RDATA  = {off_flag, win_flag, 3'h0, timeout_select};
  assign SERVICE_RDATA = service_value;

endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the window watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        CLOCK = 1'b0;
  logic        RST_N = 1'b0;
  logic        lp = 1'b0;
  logic        tlvl = 1'b0;
  logic        tpin = 1'b1;
  wire         tgl, sel, ack, watchdog_config;
  wire  [7:0]  data, cfg, svc;
  logic [7:0]  nres = 8'h00;
  logic [7:0]  e;
  logic [31:0] rnd = 32'h2DE0;
  int          n_errors = 0;
  int          n_checks = 0;
  int          k;
  always #2.5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (watchdog_config === 1'b1) nres <= nres + 8'h01;
  // Short tick so a full window is 32 cycles
  adwwd_top #(.TICK_CYCLES(4), .INIT_TICKS(8)) u_adwwd_top (.CLOCK(CLOCK), .RST_N(RST_N), .WR_TOGGLE(tgl),
    .WR_SEL(sel), .WR_DATA(data), .WR_ACK(ack), .CONFIG_RDATA(cfg), .SERVICE_RDATA(svc), .LOW_POWER(lp),
    .TEST_LEVEL_ON_TEST_CLOCK_PIN(tlvl), .TEST_MODE_PIN(tpin), .WDOG_RESET(watchdog_config));
  adwwd_host u_adwwd_host (.clk(CLOCK), .ack(ack), .tgl(tgl), .sel(sel), .data(data));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] nxt(input logic [7:0] d);
    return (d == 8'hAA) ? 8'h55 : 8'hAA;
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge CLOCK);
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge CLOCK);
    chk("cfg rst", 8'h00, cfg);
    @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLOCK);
    chk("svc rst", 8'h00, svc);
    chk("init flag", 8'h01, {7'h00, cfg[6]});
    u_adwwd_host.wr(1'b0, 8'h02);
    @(posedge CLOCK);
    chk("tsel", 8'h02, {5'h00, cfg[2:0]});
    u_adwwd_host.wr(1'b1, 8'h55);
    repeat (3) @(posedge CLOCK);
    chk("bad first", 8'h01, nres);
    repeat (40) @(posedge CLOCK);
    chk("init tmo", 8'h02, nres);
    u_adwwd_host.wr(1'b1, 8'hAA);
    @(posedge CLOCK);
    chk("closed", 8'h00, {7'h00, cfg[6]});
    e = 8'h55;
    for (k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      repeat (18 + rnd[1:0]) @(posedge CLOCK);
      chk("open", 8'h01, {7'h00, cfg[6]});
      u_adwwd_host.wr(1'b1, e);
      chk("svc", e, svc);
      e = nxt(e);
    end
    u_adwwd_host.wr(1'b1, e);
    repeat (3) @(posedge CLOCK);
    chk("early", 8'h03, nres);
    u_adwwd_host.wr(1'b1, 8'hAA);
    rnd = lfsr(rnd);
    repeat (19) @(posedge CLOCK);
    u_adwwd_host.wr(1'b1, rnd[7:0] | 8'h80);
    repeat (3) @(posedge CLOCK);
    chk("wrong", 8'h04, nres);
    u_adwwd_host.wr(1'b1, 8'hAA);
    repeat (40) @(posedge CLOCK);
    chk("win tmo", 8'h05, nres);
    for (k = 0; k < 2; k++) begin
      u_adwwd_host.wr(1'b1, 8'hAA);
      chk("reinit", 8'hAA, svc);
      lp <= (k == 0);
      tlvl <= (k == 1);
      tpin <= (k == 0);
      repeat (8) @(posedge CLOCK);
      chk("off", 8'h01, {7'h00, cfg[7]});
      u_adwwd_host.wr(1'b1, 8'h33);
      chk("svc off", 8'h00, svc);
      repeat (40) @(posedge CLOCK);
      chk("halt", 8'h05, nres);
      lp <= 1'b0;
      tlvl <= 1'b0;
      tpin <= 1'b1;
      repeat (8) @(posedge CLOCK);
      chk("on", 8'h00, {7'h00, cfg[7]});
    end
    chk("host tmo", 8'h00, 8'(u_adwwd_host.n_tmo));
    end_sim;
  end
endmodule
`default_nettype wire
